/* core/tpu_pkg.sv */
// shared constants and carrier types of the tdm port unit
package tpu_pkg;

    // =====================================================================
    // rate modes
    // =====================================================================
    typedef enum logic [1:0] {
        TPU_M4X32,
        TPU_M2X64,
        TPU_M1X128,
        TPU_M1X256
    } tpu_mode_t;

    localparam int unsigned TPU_LANES = 4;

    // =====================================================================
    // processor address map
    // =====================================================================
    localparam logic [15:0] TPU_BUF_BASE    = 16'ha000;
    localparam logic [7:0]  TPU_BUF_PAGE    = 8'ha0;
    localparam logic [15:0] TPU_MASK_BASE   = 16'ha100;
    localparam logic [15:0] TPU_MASK_LAST   = 16'ha10f;
    localparam logic [15:0] TPU_PREFIX_ADDR = 16'ha110;
    localparam logic [15:0] TPU_CTRL_ADDR   = 16'ha111;
    localparam logic [15:0] TPU_STAT_ADDR   = 16'ha112;

    // control and status fields
    localparam int unsigned TPU_CTRL_MODE_LSB = 0;
    localparam int unsigned TPU_CTRL_DBL_BIT  = 2;
    localparam int unsigned TPU_CTRL_HALF_BIT = 3;
    localparam int unsigned TPU_STAT_SWAP_BIT = 0;
    localparam int unsigned TPU_STAT_OVF_BIT  = 1;

    // reset values
    localparam logic [15:0] TPU_MASK_RST   = 16'h0000;
    localparam logic [7:0]  TPU_PREFIX_RST = 8'h00;
    localparam logic [3:0]  TPU_CTRL_RST   = 4'h0;

    // =====================================================================
    // frame timing, in highway bit-clock cycles at single rate
    // =====================================================================
    localparam logic [11:0] TPU_FRAME_4X32  = 12'h100;
    localparam logic [11:0] TPU_FRAME_2X64  = 12'h200;
    localparam logic [11:0] TPU_FRAME_1X128 = 12'h400;
    localparam logic [11:0] TPU_FRAME_1X256 = 12'h800;

    // =====================================================================
    // carriers
    // =====================================================================
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } tpu_dsp_req_t;

    typedef struct packed {
        logic            sel;
        logic [3:0]      vld;
        logic [3:0][6:0] idx;
        logic [3:0][7:0] data;
    } tpu_rx_ent_t;

endpackage

/* core/tpu_port_unit.sv */
// serial tdm voice port unit with swapped frame buffers and slot drive masks
// What this block does
// - four rate modes: 4x32, 2x64, 1x128, 1x256
// - two-port mode idles lanes 1 and 3
// - double clocking allowed except fastest mode
// - single rate: transmit on rise, sample fall
// - frame starts at sync 0 then 1
// - double rate: two clocks per bit
// - bytes shift most significant bit first
// - buffer reads return prefix in high byte
// - high byte of a word written to the buffer ignored
// - eight 16-bit slot valid mask registers
// - each mask has set and clear address
// - set address forces written ones high
// - clear address forces written ones low
// - drive enable gates lane and pin
// - 4x32: mask 2p and 2p+1 per port
// - 2x64: masks 0-3 port0, 4-7 port2
// - 1x128: port 0 only, masks 0-7
// - 1x256: selected half only, else disabled
// - two buffers swap every frame
// - receive at a000, transmit 80 above
// - fastest mode selects first or second half
`timescale 1ns/1ps
module tpu_port_unit (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // processor access
    input  wire tpu_pkg::tpu_dsp_req_t dsp_req,
    output logic [15:0]               dsp_rdata,
    // highway
    input  wire logic                 highway_bit_clock,
    input  wire logic                 highway_frame_sync,
    input  wire logic [3:0]           serial_in_lane,
    output logic [3:0]                serial_out_lane,
    output logic [3:0]                serial_out_lane_oe,
    output logic [3:0]                slot_drive_enable
);

    // =====================================================================
    // registers
    logic [7:0][15:0]       mask_q;
    logic [7:0]             prefix_q;
    tpu_pkg::tpu_mode_t     mode_q;
    logic                   dbl_q;
    logic                   half_q;
    logic                   ovf_q;
    logic                   swap_q;
    logic [15:0]            rdata_q;
    logic [7:0]             mem_q [512];

    // =====================================================================
    // input synchronisers and edge detect
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic       clk_prev_q;
    logic       fs_prev_q;
    logic       rise_e;
    logic       fall_e;
    logic       hclk_s;
    logic       fs_s;
    logic [3:0] rx_s;

    always_ff @(posedge clk) begin
        sync1_q <= {highway_bit_clock, highway_frame_sync, serial_in_lane};
        sync2_q <= sync1_q;
    end

    assign hclk_s = sync2_q[5];
    assign fs_s   = sync2_q[4];
    assign rx_s   = sync2_q[3:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= hclk_s;
        end
    end

    assign rise_e = hclk_s & ~clk_prev_q;
    assign fall_e = ~hclk_s & clk_prev_q;

    // =====================================================================
    // frame position
    logic        dbl_eff;
    logic [11:0] period;
    logic [11:0] fcnt_q;
    logic        fstart;
    logic [11:0] rx_pos;

    // fastest mode has no double clocking
    assign dbl_eff = dbl_q && (mode_q != tpu_pkg::TPU_M1X256);

    always_comb begin
        case (mode_q)
            tpu_pkg::TPU_M4X32:  period = tpu_pkg::TPU_FRAME_4X32;
            tpu_pkg::TPU_M2X64:  period = tpu_pkg::TPU_FRAME_2X64;
            tpu_pkg::TPU_M1X128: period = tpu_pkg::TPU_FRAME_1X128;
            default:             period = tpu_pkg::TPU_FRAME_1X256;
        endcase
        if (dbl_eff) begin
            period = {period[10:0], 1'b0};
        end
    end

    assign fstart = fall_e && fs_s && !fs_prev_q;
    assign rx_pos = fstart ? 12'h000 : fcnt_q;

    // free-running between syncs so transmit can drive position 0 early
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fcnt_q    <= 12'h000;
            fs_prev_q <= 1'b0;
        end else if (fall_e) begin
            fs_prev_q <= fs_s;
            if (fstart || rx_pos == period - 12'h001) begin
                fcnt_q <= fstart ? 12'h001 : 12'h000;
            end else begin
                fcnt_q <= fcnt_q + 12'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swap_q <= 1'b0;
        end else if (fstart) begin
            swap_q <= ~swap_q;
        end
    end

    // lane to buffer index; bit 7 says the lane handles this slot
    function automatic logic [7:0] lane_map(input tpu_pkg::tpu_mode_t m, input logic h,
                                            input logic [1:0] ln, input logic [7:0] s);
        logic [7:0] r;
        r = 8'h00;
        case (m)
            tpu_pkg::TPU_M4X32:  r = {1'b1, ln, s[4:0]};
            tpu_pkg::TPU_M2X64:  r = {~ln[0], ln[1], s[5:0]};
            tpu_pkg::TPU_M1X128: r = {ln == 2'h0, s[6:0]};
            default:             r = {ln == 2'h0 && s[7] == h, s[6:0]};
        endcase
        return r;
    endfunction

    // =====================================================================
    // receive shifting
    logic [11:0]       rx_bit;
    logic              rx_smp;
    logic [3:0][6:0]   rx_sh_q;
    tpu_pkg::tpu_rx_ent_t push_ent;
    logic              push;
    logic              in_ready;

    assign rx_bit = dbl_eff ? {1'b0, rx_pos[11:1]} : rx_pos;
    // double rate samples on the second falling edge of a bit
    assign rx_smp = fall_e && (!dbl_eff || rx_pos[0]);
    assign push   = rx_smp && rx_bit[2:0] == 3'h7;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_sh_q <= '0;
        end else if (rx_smp) begin
            for (int l = 0; l < 4; l++) begin
                rx_sh_q[l] <= {rx_sh_q[l][5:0], rx_s[l]};
            end
        end
    end

    always_comb begin
        logic [7:0] mp;
        mp = 8'h00;
        push_ent.sel = swap_q;
        for (int l = 0; l < 4; l++) begin
            mp = lane_map(mode_q, half_q, 2'(l), rx_bit[10:3]);
            push_ent.vld[l]  = mp[7];
            push_ent.idx[l]  = mp[6:0];
            push_ent.data[l] = {rx_sh_q[l], rx_s[l]};
        end
    end

    // =====================================================================
    // two-entry buffer between receive and frame memory
    tpu_pkg::tpu_rx_ent_t ent_q [2];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    logic       out_valid;
    logic       out_ready;
    logic       dsp_buf;
    logic       dsp_buf_wr;

    assign in_ready  = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;
    // a processor write owns the memory port; draining waits
    assign out_ready = !dsp_buf_wr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push && in_ready) begin
                ent_q[wp_q] <= push_ent;
                wp_q        <= ~wp_q;
            end
            if (out_valid && out_ready) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'((push && in_ready) ? 1 : 0) - 2'((out_valid && out_ready) ? 1 : 0);
        end
    end

    // =====================================================================
    // processor decode
    logic        dsp_mask;
    logic [2:0]  dsp_mreg;
    logic        dsp_mclr;
    logic [8:0]  dsp_widx;

    assign dsp_buf    = dsp_req.addr[15:8] == tpu_pkg::TPU_BUF_PAGE;
    assign dsp_buf_wr = dsp_req.wr && dsp_buf;
    assign dsp_mask   = dsp_req.addr >= tpu_pkg::TPU_MASK_BASE && dsp_req.addr <= tpu_pkg::TPU_MASK_LAST;
    assign dsp_mreg   = dsp_req.addr[3:1];
    assign dsp_mclr   = dsp_req.addr[0];
    assign dsp_widx   = {~swap_q, dsp_req.addr[7:0]};

    // =====================================================================
    // frame memory: processor side and serial side
    always_ff @(posedge clk) begin
        if (dsp_buf_wr) begin
            mem_q[dsp_widx] <= dsp_req.wdata[7:0];
        end else if (out_valid) begin
            for (int l = 0; l < 4; l++) begin
                if (ent_q[rp_q].vld[l]) begin
                    mem_q[{ent_q[rp_q].sel, 1'b0, ent_q[rp_q].idx[l]}] <= ent_q[rp_q].data[l];
                end
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mask_q[i] <= tpu_pkg::TPU_MASK_RST;
            end
        end else if (dsp_req.wr && dsp_mask) begin
            if (dsp_mclr) begin
                mask_q[dsp_mreg] <= mask_q[dsp_mreg] & ~dsp_req.wdata;
            end else begin
                mask_q[dsp_mreg] <= mask_q[dsp_mreg] | dsp_req.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prefix_q <= tpu_pkg::TPU_PREFIX_RST;
            mode_q   <= tpu_pkg::tpu_mode_t'(tpu_pkg::TPU_CTRL_RST[1:0]);
            dbl_q    <= tpu_pkg::TPU_CTRL_RST[tpu_pkg::TPU_CTRL_DBL_BIT];
            half_q   <= tpu_pkg::TPU_CTRL_RST[tpu_pkg::TPU_CTRL_HALF_BIT];
        end else if (dsp_req.wr && dsp_req.addr == tpu_pkg::TPU_PREFIX_ADDR) begin
            prefix_q <= dsp_req.wdata[7:0];
        end else if (dsp_req.wr && dsp_req.addr == tpu_pkg::TPU_CTRL_ADDR) begin
            mode_q <= tpu_pkg::tpu_mode_t'(dsp_req.wdata[tpu_pkg::TPU_CTRL_MODE_LSB +: 2]);
            dbl_q  <= dsp_req.wdata[tpu_pkg::TPU_CTRL_DBL_BIT];
            half_q <= dsp_req.wdata[tpu_pkg::TPU_CTRL_HALF_BIT];
        end
    end

    // overflow is sticky; a new loss in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else if (push && !in_ready) begin
            ovf_q <= 1'b1;
        end else if (dsp_req.wr && dsp_req.addr == tpu_pkg::TPU_STAT_ADDR) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (dsp_req.rd) begin
            if (dsp_buf) begin
                rdata_q <= {prefix_q, mem_q[dsp_widx]};
            end else if (dsp_mask) begin
                rdata_q <= mask_q[dsp_mreg];
            end else if (dsp_req.addr == tpu_pkg::TPU_PREFIX_ADDR) begin
                rdata_q <= {8'h00, prefix_q};
            end else if (dsp_req.addr == tpu_pkg::TPU_CTRL_ADDR) begin
                rdata_q <= {12'h000, half_q, dbl_q, mode_q};
            end else if (dsp_req.addr == tpu_pkg::TPU_STAT_ADDR) begin
                rdata_q <= {14'h0000, ovf_q, swap_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    assign dsp_rdata = rdata_q;

    // =====================================================================
    // transmit shifting and drive enables
    logic [11:0]     tx_bit;
    logic            tx_upd;
    logic            tx_sel;
    logic [3:0][6:0] tx_sh_q;
    logic [3:0]      tx_q;
    logic [3:0]      de_q;
    logic [3:0]      lane_ok;

    assign tx_bit = dbl_eff ? {1'b0, fcnt_q[11:1]} : fcnt_q;
    assign tx_upd = rise_e && (!dbl_eff || !fcnt_q[0]);
    // slot 0 is loaded ahead of the frame start, so take the buffer about to be ours
    assign tx_sel = (tx_bit[10:0] == 11'h000) ? ~swap_q : swap_q;

    always_ff @(posedge clk) begin
        logic [7:0] mp;
        logic [7:0] by;
        mp = 8'h00;
        by = 8'h00;
        if (!rst_n) begin
            tx_sh_q <= '0;
            tx_q    <= 4'h0;
            de_q    <= 4'h0;
        end else if (tx_upd) begin
            for (int l = 0; l < 4; l++) begin
                if (tx_bit[2:0] == 3'h0) begin
                    mp = lane_map(mode_q, half_q, 2'(l), tx_bit[10:3]);
                    by = mem_q[{tx_sel, 1'b1, mp[6:0]}];
                    tx_q[l]    <= by[7];
                    tx_sh_q[l] <= by[6:0];
                    de_q[l]    <= mp[7] && mask_q[mp[6:4]][mp[3:0]];
                end else begin
                    tx_q[l]    <= tx_sh_q[l][6];
                    tx_sh_q[l] <= {tx_sh_q[l][5:0], 1'b0};
                end
            end
        end
    end

    // idle lanes are cut at once when the mode changes
    always_comb begin
        case (mode_q)
            tpu_pkg::TPU_M4X32: lane_ok = 4'hf;
            tpu_pkg::TPU_M2X64: lane_ok = 4'h5;
            default:            lane_ok = 4'h1;
        endcase
    end

    assign slot_drive_enable  = de_q & lane_ok;
    assign serial_out_lane_oe = de_q & lane_ok;
    assign serial_out_lane    = tx_q;

    // =====================================================================
    // checks
    a_mask_set_bits: assert property (@(posedge clk) disable iff (!rst_n)
        dsp_req.wr && dsp_req.addr == tpu_pkg::TPU_MASK_BASE
        |=> (mask_q[0] & $past(dsp_req.wdata)) == $past(dsp_req.wdata)
            && (mask_q[0] & ~$past(dsp_req.wdata)) == ($past(mask_q[0]) & ~$past(dsp_req.wdata)))
        else $error("mask set did not force written ones");
    a_mask_clr_bits: assert property (@(posedge clk) disable iff (!rst_n)
        dsp_req.wr && dsp_req.addr == tpu_pkg::TPU_MASK_BASE + 16'h0001
        |=> (mask_q[0] & $past(dsp_req.wdata)) == 16'h0000
            && (mask_q[0] | $past(dsp_req.wdata)) == ($past(mask_q[0]) | $past(dsp_req.wdata)))
        else $error("mask clear did not force written ones low");
    a_read_prefix_high: assert property (@(posedge clk) disable iff (!rst_n)
        dsp_req.rd && dsp_buf |=> dsp_rdata[15:8] == $past(prefix_q))
        else $error("buffer read high byte is not the prefix");
    a_write_low_only: assert property (@(posedge clk) disable iff (!rst_n)
        dsp_buf_wr |=> mem_q[$past(dsp_widx)] == $past(dsp_req.wdata[7:0]))
        else $error("buffer write did not store the low byte");
    a_idle_lanes_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        mode_q == tpu_pkg::TPU_M2X64 |-> !serial_out_lane_oe[1] && !serial_out_lane_oe[3]
            && !slot_drive_enable[1] && !slot_drive_enable[3])
        else $error("idle lane driven in two-port mode");
    a_one_port_only: assert property (@(posedge clk) disable iff (!rst_n)
        mode_q == tpu_pkg::TPU_M1X128 |-> slot_drive_enable[3:1] == 3'h0)
        else $error("lanes 1 to 3 enabled in single port mode");
    a_swap_per_frame: assert property (@(posedge clk) disable iff (!rst_n)
        fstart |=> swap_q != $past(swap_q) ##1 $stable(swap_q))
        else $error("buffers not swapped at frame start");
    a_frame_start_pos: assert property (@(posedge clk) disable iff (!rst_n)
        fall_e && fs_s && !fs_prev_q |=> fcnt_q == 12'h001)
        else $error("frame position not restarted by sync");
    a_double_second_fall: assert property (@(posedge clk) disable iff (!rst_n)
        rx_smp && dbl_eff |-> rx_pos[0] && !rise_e)
        else $error("double rate sampled on first falling edge");

endmodule

/* verif/tpu_highway_model.sv */
// far-side highway device: free-running bit clock, frame sync and receive lanes
`timescale 1ns/1ps
module tpu_highway_model (
    // control from the bench
    input  wire logic        run,
    input  wire logic [11:0] frame_bits,
    // highway
    output logic             bit_clock,
    output logic             frame_sync,
    output logic [3:0]       rx_lanes
);
    logic [7:0] v;

    // =========================================
    // frame generator, 80 ns bit clock
    // =========================================
    // byte of lane l in slot s, so each slot is told apart
    function automatic logic [7:0] pat(input int l, input int s);
        return 8'(l * 64 + s) ^ 8'h5a;
    endfunction

    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        rx_lanes = 4'h0;
        forever begin
            if (!run) begin
                #40;
            end else begin
                for (int b = 0; b < int'(frame_bits); b++) begin
                    #40 bit_clock = 1'b1;
                    // high over the first fall only: a 0 then 1 sample marks the start
                    frame_sync = (b == 0);
                    for (int l = 0; l < 4; l++) begin
                        v = pat(l, (b / 8) % 32);
                        rx_lanes[l] = v[7 - b % 8];
                    end
                    #40 bit_clock = 1'b0;
                end
            end
        end
    end
endmodule

/* verif/tpu_port_unit_tb_top.sv */
// self-checking testbench of the tdm port unit
`timescale 1ns/1ps
module tpu_port_unit_tb_top;
    logic                  clk;
    logic                  rst_n;
    tpu_pkg::tpu_dsp_req_t req;
    logic [15:0]           rdata;
    logic                  bclk;
    logic                  fsync;
    logic                  run;
    logic [11:0]           frame_bits;
    logic [3:0]            rxl;
    logic [3:0]            txl;
    logic [3:0]            oe;
    logic [3:0]            sde;
    logic [15:0]           m [8];
    logic [15:0]           v;
    logic [7:0]            p;
    logic [7:0]            b;
    int                    i;
    int                    c;
    int                    s;
    int                    cyc;
    int                    failures;
    int                    samples_checked;
    integer                seed;
    logic [7:0]            tsh [4];
    logic [7:0]            tcap [4][32];
    logic [7:0]            tx_b [4];
    int                    bpos;

    // =========================================
    // clock, design and far side
    // =========================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    tpu_port_unit DUT (
        .clk                (clk),
        .rst_n              (rst_n),
        .dsp_req            (req),
        .dsp_rdata          (rdata),
        .highway_bit_clock  (bclk),
        .highway_frame_sync (fsync),
        .serial_in_lane     (rxl),
        .serial_out_lane    (txl),
        .serial_out_lane_oe (oe),
        .slot_drive_enable  (sde)
    );

    tpu_highway_model HWY (
        .run        (run),
        .frame_bits (frame_bits),
        .bit_clock  (bclk),
        .frame_sync (fsync),
        .rx_lanes   (rxl)
    );

    // =========================================
    // checking and bus tasks
    // =========================================
    task automatic complete_run();
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        req.rd <= !w;
        req.wr <= w;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        #1;
        chk(rdata, e);
    endtask

    // lane enables seen over one frame, after one frame to align
    task automatic oe_win(input logic [3:0] ctl, input logic [11:0] fb, input logic [3:0] e_or,
                          input logic [3:0] e_and);
        logic [3:0] o;
        logic [3:0] a;
        logic       same;
        o = 4'h0;
        a = 4'hf;
        same = 1'b1;
        bus(1'b1, tpu_pkg::TPU_CTRL_ADDR, {12'h000, ctl});
        frame_bits <= fb;
        repeat (int'(fb) * 10) @(posedge clk);
        repeat (int'(fb) * 10) begin
            @(posedge clk);
            #1;
            o = o | oe;
            a = a & oe;
            if (sde !== oe) same = 1'b0;
        end
        chk({12'h000, o}, {12'h000, e_or});
        chk({12'h000, a}, {12'h000, e_and});
        chk({15'h0000, same}, 16'h0001);
    endtask

    function automatic logic [7:0] exp_rx(input logic [1:0] l, input logic [4:0] sl);
        return {l, 1'b0, sl} ^ 8'h5a;
    endfunction

    // far end of the transmit lanes: last byte seen per lane and slot, frame aligned
    always @(negedge bclk) begin
        bpos = fsync ? 0 : bpos + 1;
        for (int l = 0; l < 4; l++) begin
            tsh[l] = {tsh[l][6:0], txl[l]};
            if (bpos % 8 == 7) tcap[l][(bpos / 8) % 32] = tsh[l];
        end
    end

    // hang guard: whole run is about 85k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            failures++;
            complete_run();
        end
    end

    // =========================================
    // main sequence
    // =========================================
    initial begin
        seed = 32'h6433e793;
        rst_n = 1'b0;
        req = '0;
        run = 1'b0;
        frame_bits = 12'h100;
        for (int k = 0; k < 8; k++) m[k] = 16'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 19; k++) rd_chk(16'ha100 + 16'(k), 16'h0000);
        rd_chk(16'ha113, 16'h0000);
        rd_chk(16'h9fff, 16'h0000);
        p = 8'($random(seed));
        bus(1'b1, tpu_pkg::TPU_PREFIX_ADDR, {8'($random(seed)), p});
        rd_chk(tpu_pkg::TPU_PREFIX_ADDR, {8'h00, p});
        // link stopped, so no swap between write and read back
        for (int k = 0; k < 4; k++) begin
            v = 16'ha080 + 16'($random(seed) & 127);
            b = 8'($random(seed));
            bus(1'b1, v, {8'($random(seed)), b});
            rd_chk(v, {p, b});
        end
        for (int k = 0; k < 48; k++) begin
            i = $random(seed) & 7;
            c = $random(seed) & 1;
            v = 16'($random(seed));
            bus(1'b1, 16'ha100 + 16'(2 * i + c), v);
            m[i] = (c == 1) ? (m[i] & ~v) : (m[i] | v);
            rd_chk(16'ha100 + 16'(2 * i + 1 - c), m[i]);
        end
        for (int k = 0; k < 8; k++) bus(1'b1, 16'ha100 + 16'(2 * k), 16'hffff);
        run <= 1'b1;
        repeat (10240) @(posedge clk);
        for (int k = 0; k < 24; k++) begin
            i = $random(seed) & 3;
            s = $random(seed) & 31;
            rd_chk(16'ha000 + 16'(i * 32 + s), {p, exp_rx(2'(i), 5'(s))});
        end
        // one byte per lane, written early in two frames in a row so both buffers hold it
        for (int k = 0; k < 4; k++) tx_b[k] = 8'($random(seed));
        s = $random(seed) & 31;
        repeat (2) begin
            @(posedge fsync);
            repeat (16) @(posedge clk);
            for (int k = 0; k < 4; k++) bus(1'b1, 16'ha080 + 16'(k * 32 + ((s + k) & 31)), {8'($random(seed)), tx_b[k]});
        end
        repeat (2600) @(posedge clk);
        for (int k = 0; k < 4; k++) chk({8'h00, tcap[k][(s + k) & 31]}, {8'h00, tx_b[k]});
        oe_win(4'h0, 12'h100, 4'hf, 4'hf);
        oe_win(4'h1, 12'h100, 4'h5, 4'h5);
        oe_win(4'h2, 12'h100, 4'h1, 4'h1);
        oe_win(4'h6, 12'h100, 4'h1, 4'h1);
        oe_win(4'hf, 12'h800, 4'h1, 4'h0);
        for (int k = 0; k < 8; k++) bus(1'b1, 16'ha101 + 16'(2 * k), 16'hffff);
        oe_win(4'h0, 12'h100, 4'h0, 4'h0);
        complete_run();
    end
endmodule
